// ### rtl/rpm_monitor.sv
// reference period monitor with axi4-lite register slave
`timescale 1ns/10ps
//
// How it works
// [R1] comparator run with error sum above plus window flags fast
// [R2] comparator run with error sum below minus window flags slow
// [R3] comparison happens only on ticks whose edge tally is nonzero
// [R4] span timer counts precision reciprocal sample ticks per span
// [R5] outer limit faults a valid reference, inner limit unfaults it
// [R6] both limits are 20-bit reciprocals of fractional tolerance
// [R7] sample tick every 32 clocks, valued 32 times system period
// [R8] window starts at three times 32 times system period
// [R9] at least seven spans observed before good or full verdict
// [R10] window grows by 32 system periods each span after first
// [R11] observation lasts at least seven spans and until two reference edges are seen
// [R12] 6-bit edge tally, cleared on each sample tick
// [R13] error sum adds tally times expected period minus tick value
// [R14] system period 21-bit fs, expected period 50-bit fs
// [R15] end of observation clears sum, timer and tally
// [R16] limit chosen by fault state; fast and slow held to next verdict
// [R17] signed wide datapaths never overflow
module rpm_monitor
   import rpm_pkg::*;
#(
   parameter int SPAN_W = SPAN_CNT_W
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ref_clk,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic ref_fast,
   output logic ref_slow,
   output logic irq
);
   // elaboration check: span count must fit the compare logic
   if (SPAN_W < 8 || SPAN_W > 24)
   begin : g_span_w_check
      $error("span counter width out of range");
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // [R14] period settings
   logic [SYS_PERIOD_W-1:0] sys_period_q;
   logic [EXP_PERIOD_W-1:0] exp_period_q;
   // [R6] tolerance reciprocals
   logic [LIMIT_W-1:0] outer_limit_reciprocal_q;
   logic [LIMIT_W-1:0] inner_limit_reciprocal_q;
   logic enable_q;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic faulted_q;
   logic good_q;
   logic ev_fast, ev_slow, ev_good;

   logic aw_held_q, w_held_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic do_write;
   assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a[1:0] == 2'h0) && (a <= ADDR_CTRL);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (st[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      merge = r;
   endfunction

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr[7:0];
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_ok(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   logic [31:0] cur_w;
   always_comb
   begin
      unique case (aw_addr_q)
         ADDR_SYS_PERIOD: cur_w = {11'h0, sys_period_q};
         ADDR_EXP_LO: cur_w = exp_period_q[31:0];
         ADDR_EXP_HI: cur_w = {14'h0, exp_period_q[49:32]};
         ADDR_OUTER: cur_w = {12'h0, outer_limit_reciprocal_q};
         ADDR_INNER: cur_w = {12'h0, inner_limit_reciprocal_q};
         ADDR_IRQ_MASK: cur_w = {29'h0, irq_mask_q};
         ADDR_CTRL: cur_w = {31'h0, enable_q};
         default: cur_w = 32'h0;
      endcase
   end

   logic [31:0] wv;
   assign wv = merge(cur_w, w_data_q, w_strb_q);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sys_period_q <= SYS_PERIOD_RST;
         exp_period_q <= 50'h0;
         outer_limit_reciprocal_q <= LIMIT_RST;
         inner_limit_reciprocal_q <= LIMIT_RST;
         irq_mask_q <= 3'h0;
         enable_q <= 1'b0;
      end
      else if (do_write)
      begin
         unique case (aw_addr_q)
            ADDR_SYS_PERIOD: sys_period_q <= wv[SYS_PERIOD_W-1:0];
            ADDR_EXP_LO: exp_period_q[31:0] <= wv;
            ADDR_EXP_HI: exp_period_q[49:32] <= wv[17:0];
            ADDR_OUTER: outer_limit_reciprocal_q <= wv[LIMIT_W-1:0];
            ADDR_INNER: inner_limit_reciprocal_q <= wv[LIMIT_W-1:0];
            ADDR_IRQ_MASK: irq_mask_q <= wv[IRQ_W-1:0];
            ADDR_CTRL: enable_q <= wv[0];
            default: ;
         endcase
      end
   end

   // sticky events, set wins over write-one-to-clear
   logic [IRQ_W-1:0] ev_vec, clr_vec;
   assign ev_vec = {ev_good, ev_slow, ev_fast};
   assign clr_vec = (do_write && aw_addr_q == ADDR_IRQ_STAT) ?
                    (w_data_q[IRQ_W-1:0] & {IRQ_W{w_strb_q[0]}}) : 3'h0;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_stat_q <= 3'h0;
         irq <= 1'b0;
      end
      else
      begin
         irq_stat_q <= (irq_stat_q & ~clr_vec) | ev_vec;
         irq <= |(((irq_stat_q & ~clr_vec) | ev_vec) & irq_mask_q);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= addr_ok(s_axi_araddr[7:0]) ? RESP_OKAY
                                                      : RESP_SLVERR;
            unique case (s_axi_araddr[7:0])
               ADDR_SYS_PERIOD: s_axi_rdata <= {11'h0, sys_period_q};
               ADDR_EXP_LO: s_axi_rdata <= exp_period_q[31:0];
               ADDR_EXP_HI: s_axi_rdata <= {14'h0, exp_period_q[49:32]};
               ADDR_OUTER: s_axi_rdata <= {12'h0, outer_limit_reciprocal_q};
               ADDR_INNER: s_axi_rdata <= {12'h0, inner_limit_reciprocal_q};
               ADDR_STATUS: s_axi_rdata <= {28'h0, faulted_q, good_q,
                                           ref_slow, ref_fast};
               ADDR_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat_q};
               ADDR_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask_q};
               ADDR_CTRL: s_axi_rdata <= {31'h0, enable_q};
               default: s_axi_rdata <= 32'h0;
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // reference input and sample tick
   // ------------------------------------------------------------
   logic ref_s1_q, ref_s2_q, ref_s3_q;
   logic ref_rise;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ref_s1_q <= 1'b0;
         ref_s2_q <= 1'b0;
         ref_s3_q <= 1'b0;
      end
      else
      begin
         ref_s1_q <= ref_clk;
         ref_s2_q <= ref_s1_q;
         ref_s3_q <= ref_s2_q;
      end
   end
   // edges faster than half the clock are not resolvable
   assign ref_rise = ref_s2_q && !ref_s3_q;

   // [R7] divide by 32 for the sample tick
   logic [TICK_CNT_W-1:0] div_q;
   logic tick;
   assign tick = (div_q == TICK_CNT_W'(TICK_DIV - 1));
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !enable_q)
         div_q <= '0;
      else
         div_q <= div_q + 1'b1;
   end

   // ------------------------------------------------------------
   // measurement datapath
   // ------------------------------------------------------------
   logic [EDGE_W-1:0] tally_q;
   logic [EDGE_W-1:0] tally_now;
   logic signed [SUM_W-1:0] error_sum_q;
   logic signed [SUM_W-1:0] error_sum_next;
   logic signed [SUM_W-1:0] tick_value;
   logic signed [SUM_W-1:0] decision_window_q;
   logic [LIMIT_W-1:0] span_tick_q;
   logic [SPAN_W-1:0] spans_q;
   logic [1:0] edges_seen_q;
   logic [LIMIT_W-1:0] limit_sel;
   logic span_end, obs_end, cmp_run, is_fast, is_slow;

   // an edge landing on the tick cycle counts into the new tally
   assign tally_now = tally_q;
   // [R7] digital tick value
   assign tick_value = SUM_W'(sys_period_q) * SUM_W'(TICK_DIV);
   // [R13] [R17] signed wide accumulation
   assign error_sum_next = error_sum_q
                         + SUM_W'(tally_now) * SUM_W'(exp_period_q)
                         - tick_value;
   // [R5] [R16] limit follows fault state
   assign limit_sel = faulted_q ? inner_limit_reciprocal_q
                                : outer_limit_reciprocal_q;
   // [R4] span ends after precision_reciprocal ticks
   assign span_end = tick && (span_tick_q + 1'b1 >= limit_sel);
   // [R9] [R11] end needs seven spans and two reference edges
   // no increment here, so a saturated span count cannot wrap
   assign obs_end = span_end && (spans_q >= SPAN_W'(MIN_SPANS - 1))
                    && (edges_seen_q == 2'h2);
   // [R3] compare only on nonzero tally
   assign cmp_run = tick && (tally_now != '0);
   // [R1] fast
   assign is_fast = error_sum_next > decision_window_q;
   // [R2] slow
   assign is_slow = error_sum_next < -decision_window_q;

   // [R12] edge tally cleared each tick
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !enable_q)
         tally_q <= '0;
      else if (tick)
         tally_q <= {{(EDGE_W-1){1'b0}}, ref_rise};
      else if (ref_rise && tally_q != {EDGE_W{1'b1}})
         tally_q <= tally_q + 1'b1;
   end

   // [R15] restart on observation end
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !enable_q)
      begin
         error_sum_q <= '0;
         span_tick_q <= '0;
         spans_q <= '0;
         edges_seen_q <= 2'h0;
      end
      else if (obs_end || (cmp_run && (is_fast || is_slow)))
      begin
         error_sum_q <= '0;
         span_tick_q <= '0;
         spans_q <= '0;
         edges_seen_q <= 2'h0;
      end
      else
      begin
         if (tick)
            error_sum_q <= error_sum_next;
         if (span_end)
         begin
            span_tick_q <= '0;
            if (spans_q != {SPAN_W{1'b1}})
               spans_q <= spans_q + 1'b1;
         end
         else if (tick)
            span_tick_q <= span_tick_q + 1'b1;
         if (ref_rise && edges_seen_q != 2'h2)
            edges_seen_q <= edges_seen_q + 1'b1;
      end
   end

   // [R8] [R10] window is (3 + spans) tick values
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !enable_q)
         decision_window_q <= '0;
      else
         decision_window_q <= tick_value * SUM_W'(BASE_WINDOW_MULT)
                            + tick_value * SUM_W'(spans_q);
   end

   // [R16] verdict held until the next one
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ref_fast <= 1'b0;
         ref_slow <= 1'b0;
         good_q <= 1'b0;
         faulted_q <= 1'b0;
      end
      else if (cmp_run && (is_fast || is_slow))
      begin
         ref_fast <= is_fast;
         ref_slow <= is_slow;
         good_q <= 1'b0;
         faulted_q <= 1'b1;
      end
      else if (obs_end)
      begin
         ref_fast <= 1'b0;
         ref_slow <= 1'b0;
         good_q <= 1'b1;
         faulted_q <= 1'b0;
      end
   end

   assign ev_fast = cmp_run && is_fast;
   assign ev_slow = cmp_run && is_slow;
   assign ev_good = obs_end && !(cmp_run && (is_fast || is_slow));

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   fast_flag_a: assert property ( // [R1]
      @(posedge aclk) disable iff (!aresetn)
      ev_fast |=> ref_fast && !ref_slow)
      else $error("fast verdict not flagged");
   slow_flag_a: assert property ( // [R2]
      @(posedge aclk) disable iff (!aresetn)
      ev_slow |=> ref_slow && !ref_fast)
      else $error("slow verdict not flagged");
   // a good verdict may land on an empty tick and clear the flags
   zero_tally_a: assert property ( // [R3]
      @(posedge aclk) disable iff (!aresetn)
      tick && tally_q == '0 && !obs_end
      |=> $stable(ref_fast) && $stable(ref_slow))
      else $error("verdict changed on empty tally");
   tick_spacing_a: assert property ( // [R7]
      @(posedge aclk) disable iff (!aresetn)
      tick && enable_q |=> !tick [*8])
      else $error("sample ticks too close");
   // window register lags the span count by one cycle
   first_window_a: assert property ( // [R8]
      @(posedge aclk) disable iff (!aresetn)
      enable_q && $past(enable_q) && spans_q == '0 && $stable(spans_q)
      && $stable(sys_period_q)
      |-> decision_window_q == tick_value * SUM_W'(BASE_WINDOW_MULT))
      else $error("first window wrong");
   min_spans_a: assert property ( // [R9]
      @(posedge aclk) disable iff (!aresetn)
      ev_good |-> spans_q >= SPAN_W'(MIN_SPANS - 1))
      else $error("good declared too early");
   restart_a: assert property ( // [R15]
      @(posedge aclk) disable iff (!aresetn)
      obs_end && enable_q |=> error_sum_q == '0 && spans_q == '0)
      else $error("observation not restarted");
   tally_clear_a: assert property ( // [R12]
      @(posedge aclk) disable iff (!aresetn)
      tick |=> tally_q <= EDGE_W'(1))
      else $error("tally not cleared on tick");
   irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 irq == |(irq_stat_q & $past(irq_mask_q)))
      else $error("interrupt level wrong");
endmodule // rpm_monitor

// ### rtl/rpm_pkg.sv
// constants and types for the reference period monitor
package rpm_pkg;
   // sample tick is one thirty-second of the system clock
   localparam int TICK_DIV = 32;
   localparam int TICK_CNT_W = 5;
   localparam int EDGE_W = 6;
   localparam int SYS_PERIOD_W = 21;
   localparam int EXP_PERIOD_W = 50;
   localparam int LIMIT_W = 20;
   localparam int MIN_SPANS = 7;
   localparam int BASE_WINDOW_MULT = 3;
   localparam int SPAN_CNT_W = 16;
   localparam int SUM_W = 80;
   // axi register byte addresses
   localparam logic [7:0] ADDR_SYS_PERIOD = 8'h00;
   localparam logic [7:0] ADDR_EXP_LO = 8'h04;
   localparam logic [7:0] ADDR_EXP_HI = 8'h08;
   localparam logic [7:0] ADDR_OUTER = 8'h0c;
   localparam logic [7:0] ADDR_INNER = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
   localparam logic [7:0] ADDR_CTRL = 8'h20;
   // status and event bit positions
   localparam int BIT_FAST = 0;
   localparam int BIT_SLOW = 1;
   localparam int BIT_GOOD = 2;
   localparam int BIT_FAULT = 3;
   localparam int IRQ_W = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [20:0] SYS_PERIOD_RST = 21'h0;
   localparam logic [19:0] LIMIT_RST = 20'h00010;
endpackage

// ### verif/rpm_ref_source.sv
// reference clock source driving the monitored input
`timescale 1ns/10ps
module rpm_ref_source (
   input wire logic aclk,
   input wire logic run,
   input wire logic [7:0] half_cycles,
   output logic ref_clk
);
   logic [7:0] cnt_q;
   initial
   begin
      ref_clk = 1'b0;
      cnt_q = 8'h00;
   end
   // ----------------------------------------
   // square wave, idle low outside runs
   // ----------------------------------------
   // halves of one clock or more, the sampler still resolves one-clock halves
   always @(posedge aclk)
   begin
      if (!run)
      begin
         ref_clk <= 1'b0;
         cnt_q <= 8'h00;
      end
      else if (cnt_q + 8'h01 >= half_cycles)
      begin
         ref_clk <= ~ref_clk;
         cnt_q <= 8'h00;
      end
      else
         cnt_q <= cnt_q + 8'h01;
   end
endmodule // rpm_ref_source

// ### verif/ref_period_monitor_tb.sv
// self-checking bench for the reference period monitor
`timescale 1ns/10ps
module ref_period_monitor_tb;
   import rpm_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0, ref_clk;
   logic [7:0] half_cycles = 8'h04;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, ref_fast, ref_slow, irq;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rd, seed = 32'h3d0be3cf;
   int errors = 0, compares = 0, v, i;
   logic [7:0] rst_addr [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
      8'h14, 8'h18, 8'h1c, 8'h20};
   logic [31:0] rst_val [9] = '{32'h0, 32'h0, 32'h0, 32'h10, 32'h10,
      32'h0, 32'h0, 32'h0, 32'h0};

   always #50 aclk = ~aclk;

   rpm_ref_source u_rpm_ref_source (.aclk(aclk), .run(run),
      .half_cycles(half_cycles), .ref_clk(ref_clk));
   rpm_monitor u_rpm_monitor (.aclk(aclk), .aresetn(aresetn),
      .ref_clk(ref_clk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .ref_fast(ref_fast), .ref_slow(ref_slow),
      .irq(irq));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // integer model: tally, signed sum, growing window, seven-span verdict
   function automatic int model_verdict(int half, longint expv,
      longint sysv, int lim);
      longint acc, win;
      int k, edges, t;
      acc = 0;
      edges = 0;
      for (t = 0; t < 400; t++)
      begin
         k = ((t + 1) * 32) / (2 * half) - (t * 32) / (2 * half);
         edges += k;
         acc += k * expv - 32 * sysv;
         win = (3 + t / lim) * 32 * sysv;
         if (k != 0 && acc > win)
            return 1;
         if (k != 0 && acc < -win)
            return 2;
         if ((t + 1) % lim == 0 && (t + 1) / lim >= 7 && edges >= 2)
            return 4;
      end
      return 0;
   endfunction

   task automatic stop_test();
      $display("checks %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk_val(string what, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic timed_out(string what);
      errors++;
      $display("[ERR] %s expected answer seen timeout", what);
      stop_test();
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge aclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
         if (bvalid === 1'b1)
            break;
      end
      if (n == 100)
         timed_out("write response");
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
      int n;
      @(posedge aclk);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge aclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
         if (rvalid === 1'b1)
            break;
      end
      if (n == 100)
         timed_out("read data");
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   task automatic wait_flags(logic [1:0] exp, int bound, string what);
      int n;
      for (n = 0; n < bound; n++)
      begin
         @(posedge aclk);
         if ({ref_slow, ref_fast} === exp)
            break;
      end
      if (n == bound)
         timed_out(what);
      chk_val(what, {30'h0, exp}, {30'h0, ref_slow, ref_fast});
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 9; i++)
      begin
         axi_read(rst_addr[i], rd);
         chk_val("reset value", rst_val[i], rd);
      end
      axi_read(8'h24, rd);
      chk_val("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      chk_val("unmapped data", 32'h0, rd);
      axi_write(8'h22, 32'h1);
      chk_val("unaligned wresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      wstrb <= 4'h1;
      axi_write(ADDR_INNER, 32'hffffffff);
      wstrb <= 4'hf;
      chk_val("strobe wresp", {30'h0, RESP_OKAY}, {30'h0, resp});
      axi_read(ADDR_INNER, rd);
      chk_val("byte strobe", 32'hff, rd);
      axi_write(ADDR_STATUS, 32'hf);
      axi_read(ADDR_STATUS, rd);
      chk_val("status read only", 32'h0, rd);
      seed = xorshift(seed);
      axi_write(ADDR_SYS_PERIOD, seed);
      axi_read(ADDR_SYS_PERIOD, rd);
      chk_val("sys period width", seed & 32'h1fffff, rd);
      seed = xorshift(seed);
      axi_write(ADDR_OUTER, seed);
      axi_read(ADDR_OUTER, rd);
      chk_val("outer limit width", seed & 32'hfffff, rd);
      $display("register test done");

      // exact period: good only after seven spans of eight ticks
      axi_write(ADDR_SYS_PERIOD, 32'd1000);
      axi_write(ADDR_EXP_LO, 32'd8000);
      axi_write(ADDR_OUTER, 32'd8);
      axi_write(ADDR_INNER, 32'd8);
      half_cycles <= 8'h04;
      run <= 1'b1;
      axi_write(ADDR_CTRL, 32'h1);
      v = model_verdict(4, 8000, 1000, 8);
      // seven spans of eight ticks take about 1800 clocks
      for (i = 0; i < 1000; i++)
      begin
         axi_read(ADDR_STATUS, rd);
         if (rd[BIT_GOOD] === 1'b1)
            break;
      end
      if (i == 1000)
         timed_out("good verdict");
      chk_val("good verdict", v, {29'h0, rd[2:0]});
      chk_val("irq masked", 32'h0, {31'h0, irq});
      axi_read(ADDR_IRQ_STAT, rd);
      chk_val("good event", 32'h4, rd & 32'h4);
      axi_write(ADDR_IRQ_MASK, 32'h4);
      repeat (3) @(posedge aclk);
      chk_val("irq unmasked", 32'h1, {31'h0, irq});
      axi_write(ADDR_CTRL, 32'h0);
      axi_write(ADDR_IRQ_STAT, 32'h7);
      axi_read(ADDR_IRQ_STAT, rd);
      chk_val("event cleared", 32'h0, rd);
      repeat (3) @(posedge aclk);
      chk_val("irq cleared", 32'h0, {31'h0, irq});
      $display("good test done");

      // absent reference: zero tallies never run the comparator
      run <= 1'b0;
      axi_write(ADDR_CTRL, 32'h1);
      repeat (2000) @(posedge aclk);
      chk_val("no verdict", 32'h0, {30'h0, ref_slow, ref_fast});
      $display("absent test done");

      v = model_verdict(8, 8000, 1000, 8);
      half_cycles <= 8'h08;
      run <= 1'b1;
      wait_flags(v == 2 ? 2'b10 : 2'b00, 4000, "slow flag");
      run <= 1'b0;
      repeat (1500) @(posedge aclk);
      chk_val("slow held", 32'h2, {30'h0, ref_slow, ref_fast});
      $display("slow test done");

      v = model_verdict(3, 8000, 1000, 8);
      half_cycles <= 8'h03;
      run <= 1'b1;
      wait_flags(v == 1 ? 2'b01 : 2'b00, 6000, "fast flag");
      axi_read(ADDR_STATUS, rd);
      chk_val("fast status", 32'h1, rd & 32'h3);
      $display("fast test done");
      stop_test();
   end
endmodule // ref_period_monitor_tb
